// ==== common/transfer_if.sv ====
// row-wide transfer path between the array controller and the serial shifter
// assumes: load_row and start_code stay stable while load_toggle crosses
`timescale 1ns/1ps
interface transfer_if;
    logic [vdram_pkg::SLICES-1:0][vdram_pkg::COLS-1:0] load_row;
    logic [vdram_pkg::SEG_CODE_W-1:0] start_code;
    logic load_toggle;
    logic [vdram_pkg::SLICES-1:0][vdram_pkg::COLS-1:0] shift_state;

    modport ctrl (
        output load_row,
        output start_code,
        output load_toggle,
        input shift_state
    );
    modport shifter (
        input load_row,
        input start_code,
        input load_toggle,
        output shift_state
    );
endinterface

// ==== common/vdram_pkg.sv ====
// constants and types shared by the video dram transfer block
// assumes: four one-bit memory slices, each a 256 x 256 cell array
package vdram_pkg;
    localparam int SLICES = 4;
    localparam int ROW_BITS = 8;
    localparam int COL_BITS = 8;
    localparam int ROWS = 256;
    localparam int COLS = 256;
    localparam int SEG_BITS = 64;
    localparam int SEG_CODE_W = 2;
    localparam int SEG_CODE_MSB = 7;
    localparam int SEG_CODE_LSB = 6;
    localparam int SYNC_STAGES = 2;
    localparam int PIN_COUNT = 20;
    localparam logic [SEG_CODE_W-1:0] SEG_CODE_RESET = 2'h0;
    localparam logic [ROW_BITS-1:0] ROW_RESET = 8'h00;
    localparam logic [COL_BITS-1:0] COL_RESET = 8'h00;
    localparam logic [SLICES-1:0] SLICE_NONE = 4'h0;

    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_RANDOM = 2'b01,
        CYC_TO_ARRAY = 2'b10,
        CYC_TO_REG = 2'b11
    } cycle_e;

    // first bit position of the segment named by a start code
    function automatic logic [COL_BITS-1:0] seg_base(input logic [SEG_CODE_W-1:0] code);
        return {code, 6'h00};
    endfunction
endpackage

// ==== dv/serial_controller_model.sv ====
// controller side of the serial port: serial clock and serial data in
// assumes: bench fills pattern before run and reads captured after it
`timescale 1ns/1ps
module serial_controller_model (
    output logic serial_clock,
    output logic [vdram_pkg::SLICES-1:0] serial_input,
    input wire logic [vdram_pkg::SLICES-1:0] serial_output
);
    logic [vdram_pkg::SLICES-1:0] pattern [256];
    logic [vdram_pkg::SLICES-1:0] captured [256];
    initial begin
        serial_clock = 1'h0;
        serial_input = 4'h0;
    end
    // clock stands low between frames, so no edge lands near a transfer row fall
    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            serial_input = pattern[i];
            #16;
            captured[i] = serial_output;
            serial_clock = 1'h1;
            #16;
            serial_clock = 1'h0;
        end
        serial_input = ~serial_input;
        // a quiet gap so back-to-back frames never set data twice in one step
        #16;
    endtask
endmodule // serial_controller_model

// ==== dv/tb_dual_port_video_dram_transfer.sv ====
// self-checking bench for the video dram top with a serial controller model
// assumes: inputs change at clk falling edges; serial clock made by the model
`timescale 1ns/1ps
module tb_dual_port_video_dram_transfer;
    typedef struct {logic [7:0] row; logic [7:0] col; logic [3:0] data;} case_s;
    case_s cases [4] = '{'{8'h00, 8'h00, 4'h5}, '{8'hff, 8'hff, 4'ha},
                         '{8'h12, 8'h34, 4'hf}, '{8'h12, 8'h35, 4'h0}};
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic row_strobe_n = 1'h1;
    logic [3:0] column_strobe_n = 4'hf;
    logic write_select_n = 1'h1;
    logic ts_n = 1'h1;
    logic [7:0] addr = 8'h00;
    logic [3:0] data_in = 4'h0;
    logic so_en_n = 1'h0;
    logic serial_clock, serial_output_oe;
    logic [3:0] serial_input, serial_output, data_out, data_oe;
    logic [3:0] exp_bits [256];
    int errors = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    video_dram_top dut (.clk(clk), .rst_n(rst_n), .serial_clock(serial_clock),
        .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
        .write_select_n(write_select_n), .transfer_select_output_enable_n(ts_n),
        .multiplexed_address(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .serial_input(serial_input), .serial_output(serial_output),
        .serial_output_oe(serial_output_oe), .serial_output_enable_n(so_en_n));
    serial_controller_model part (.serial_clock(serial_clock), .serial_input(serial_input),
        .serial_output(serial_output));
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d errors=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // output enable goes low with the column strobe so early writes are exercised too
    task automatic ram_cycle(input logic [7:0] row, col, input logic we_n, input logic [3:0] wd, exp);
        @(negedge clk);
        addr = row;
        row_strobe_n = 1'h0;
        wait_clk(4);
        addr = col;
        data_in = wd;
        write_select_n = we_n;
        ts_n = 1'h0;
        column_strobe_n = 4'h0;
        wait_clk(6);
        check(data_oe, we_n ? 4'hf : 4'h0);
        if (we_n)
            check(data_out, exp);
        column_strobe_n = 4'hf;
        ts_n = 1'h1;
        write_select_n = 1'h1;
        wait_clk(4);
        row_strobe_n = 1'h1;
        wait_clk(4);
    endtask
    task automatic transfer(input logic [7:0] row, input logic we_n, col, input logic [1:0] code);
        @(negedge clk);
        addr = row;
        ts_n = 1'h0;
        write_select_n = we_n;
        row_strobe_n = 1'h0;
        wait_clk(4);
        if (col) begin
            addr = {code, 6'h00};
            column_strobe_n = 4'h0;
            wait_clk(4);
            column_strobe_n = 4'hf;
        end
        check(data_oe, 4'h0);
        wait_clk(4);
        ts_n = 1'h1;
        write_select_n = 1'h1;
        row_strobe_n = 1'h1;
        wait_clk(5);
    endtask
    // two flush edges then the load edge, before the loaded bits are walked out
    task automatic shift_check(input int base, input int n);
        part.run(3);
        part.run(n);
        for (int i = 0; i < n; i++)
            check(part.captured[i], exp_bits[base+i]);
    endtask
    initial begin
        #200_000;
        errors++;
        summarize();
    end
    initial begin
        fork
            part.run(2);
            wait_clk(2);
        join
        rst_n = 1'h1;
        check(data_oe, 4'h0);
        wait_clk(4);
        check({3'h0, serial_output_oe}, 4'h1);
        foreach (cases[i]) ram_cycle(cases[i].row, cases[i].col, 1'h0, cases[i].data, 4'h0);
        foreach (cases[i]) ram_cycle(cases[i].row, cases[i].col, 1'h1, 4'h0, cases[i].data);
        // read-modify-write: read first, then write select falls with the column strobe low
        @(negedge clk);
        addr = 8'h12;
        row_strobe_n = 1'h0;
        wait_clk(4);
        addr = 8'h34;
        ts_n = 1'h0;
        column_strobe_n = 4'h0;
        wait_clk(6);
        check(data_out, 4'hf);
        ts_n = 1'h1;
        data_in = 4'h3;
        write_select_n = 1'h0;
        wait_clk(4);
        column_strobe_n = 4'hf;
        write_select_n = 1'h1;
        wait_clk(4);
        row_strobe_n = 1'h1;
        wait_clk(4);
        ram_cycle(8'h12, 8'h34, 1'h1, 4'h0, 4'h3);
        // row-only refresh cycle: column strobes stay high, data pins stay quiet
        @(negedge clk);
        addr = 8'h40;
        row_strobe_n = 1'h0;
        wait_clk(4);
        check(data_oe, 4'h0);
        row_strobe_n = 1'h1;
        wait_clk(4);
        for (int i = 0; i < 256; i++) begin
            exp_bits[i] = 4'(i ^ (i >> 3));
            part.pattern[i] = exp_bits[i];
        end
        fork
            part.run(256);
            ram_cycle(8'hff, 8'hff, 1'h1, 4'h0, 4'ha);
        join
        transfer(8'h40, 1'h0, 1'h0, 2'h0);
        transfer(8'h41, 1'h0, 1'h0, 2'h0);
        ram_cycle(8'h40, 8'hc5, 1'h1, 4'h0, exp_bits[8'hc5]);
        ram_cycle(8'h41, 8'h07, 1'h1, 4'h0, exp_bits[7]);
        for (int c = 0; c < 4; c++) begin
            transfer(8'h41, 1'h1, 1'h1, 2'(c));
            shift_check(64 * c, 64);
        end
        transfer(8'h40, 1'h1, 1'h0, 2'h0);
        shift_check(192, 64);
        transfer(8'h40, 1'h1, 1'h1, 2'h0);
        shift_check(0, 256);
        @(negedge clk);
        so_en_n = 1'h1;
        wait_clk(4);
        check({3'h0, serial_output_oe}, 4'h0);
        so_en_n = 1'h0;
        summarize();
    end
endmodule // tb_dual_port_video_dram_transfer
bind video_dram_top video_dram_monitor mon (.clk(clk), .rst_n(rst_n),
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_select_n(write_select_n),
    .transfer_select_output_enable_n(transfer_select_output_enable_n),
    .data_out(data_out), .data_oe(data_oe), .serial_output_oe(serial_output_oe),
    .serial_output_enable_n(serial_output_enable_n));

// ==== dv/video_dram_monitor.sv ====
// checker on the video dram top pins: data and serial drive enables
// assumes: pins are held three clk periods around each strobe edge
`timescale 1ns/1ps
module video_dram_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic row_strobe_n,
    input wire logic [vdram_pkg::SLICES-1:0] column_strobe_n,
    input wire logic write_select_n,
    input wire logic transfer_select_output_enable_n,
    input wire logic [vdram_pkg::SLICES-1:0] data_out,
    input wire logic [vdram_pkg::SLICES-1:0] data_oe,
    input wire logic serial_output_oe,
    input wire logic serial_output_enable_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic in_xfer;
    wire ts_n = transfer_select_output_enable_n;
    // cycle kind is fixed by the select level seen at the row fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            in_xfer <= 1'h0;
        else if ($fell(row_strobe_n))
            in_xfer <= !ts_n;
    end
    sequence read_open;
        !in_xfer && !row_strobe_n && write_select_n && !ts_n && !column_strobe_n[0];
    endsequence
    AST_DQ_OFF_CAS_HIGH: assert property ((&column_strobe_n) [*4] |-> data_oe == 4'h0)
        else $error("data drive without column strobe");
    AST_DQ_OFF_TS_HIGH: assert property (ts_n [*4] |-> data_oe == 4'h0)
        else $error("data drive with output enable high");
    AST_DQ_OFF_TRANSFER: assert property (in_xfer |-> data_oe == 4'h0)
        else $error("data drive during transfer cycle");
    AST_EARLY_WRITE_QUIET: assert property ($fell(column_strobe_n[0]) && !write_select_n
        |-> ##1 (!data_oe[0]) [*6]) else $error("data drive in early write");
    AST_READ_ENABLE: assert property ($fell(column_strobe_n[0]) and read_open
        ##1 read_open [*5] |-> data_oe[0]) else $error("read data not driven");
    AST_READ_HOLD: assert property (read_open and data_oe[0]
        |=> data_oe[0] && $stable(data_out[0])) else $error("read data not held");
    AST_SERIAL_OE_ON: assert property (!serial_output_enable_n [*4] |-> serial_output_oe)
        else $error("serial output not driven");
    AST_SERIAL_OE_OFF: assert property (serial_output_enable_n [*4] |-> !serial_output_oe)
        else $error("serial output driven while disabled");
endmodule // video_dram_monitor

// ==== hdl/pin_sync.sv ====
// two-flop synchroniser for a group of pin levels
// assumes: each bit is an independent level; no word coherence is promised
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RESET_VALUE;
            level <= RESET_VALUE;
        end else begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule // pin_sync

// ==== hdl/serial_shifter.sv ====
// four 256-bit serial shift registers on the serial clock
// assumes: load requests arrive as a toggle with row data held stable
`timescale 1ns/1ps
module serial_shifter (
    input wire logic serial_clock,
    input wire logic rst_n,
    transfer_if.shifter xfer,
    input wire logic [vdram_pkg::SLICES-1:0] serial_input,
    output logic [vdram_pkg::SLICES-1:0] serial_output
);
    logic [vdram_pkg::SLICES-1:0][vdram_pkg::COLS-1:0] chain;
    logic [vdram_pkg::SEG_CODE_W-1:0] start_code;
    logic toggle_meta;
    logic toggle_sync;
    logic toggle_seen;
    logic load_pending;
    logic [vdram_pkg::COL_BITS-1:0] tap;

    assign load_pending = toggle_sync ^ toggle_seen;
    assign tap = vdram_pkg::seg_base(start_code);
    assign xfer.shift_state = chain;

    // first bit out is the base of the chosen segment, then upward to bit 255
    genvar s;
    generate
        for (s = 0; s < vdram_pkg::SLICES; s++) begin : g_out
            assign serial_output[s] = chain[s][tap];
        end
    endgenerate

    always_ff @(posedge serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            toggle_meta <= 1'b0;
            toggle_sync <= 1'b0;
        end else begin
            toggle_meta <= xfer.load_toggle;
            toggle_sync <= toggle_meta;
        end
    end

    // a pending parallel load takes the place of one shift edge
    always_ff @(posedge serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            toggle_seen <= 1'b0;
            start_code <= vdram_pkg::SEG_CODE_RESET;
            chain <= '0;
        end else if (load_pending) begin
            toggle_seen <= toggle_sync;
            start_code <= xfer.start_code;
            chain <= xfer.load_row;
        end else begin
            for (int i = 0; i < vdram_pkg::SLICES; i++) begin
                chain[i] <= {serial_input[i], chain[i][vdram_pkg::COLS-1:1]};
            end
        end
    end
endmodule // serial_shifter

// ==== hdl/video_dram_top.sv ====
// dual-port video memory: random-access dram array plus serial shift port
// assumes: strobes and data pins are asynchronous to clk and held for
// at least three clk periods; serial_clock is a separate free domain
//
// Function
// - register-to-array transfer writes all 256 register bits into the addressed row.
// - array-to-register transfer loads all 256 register bits from the addressed row.
// - write, read-modify-write and read cycles may mix in any order.
// - repeated register-to-array cycles copy the same registers into many rows.
// - random-access data pins stay undriven throughout every transfer cycle.
// - segment code only changes when column strobe falls in an array-to-register transfer.
// - random port presents 65,536 words of four bits, one per slice.
// - four 256-bit shift registers, each four cascaded 64-bit segments.
// - top two column bits latched at transfer select the first segment.
// - each segment shifts out least significant bit first, starting at the chosen segment and ascending.
// - with segment code 00 all 256 bits leave each serial output.
// - random and serial ports run independently except during transfers.
// - an array-to-register transfer also refreshes the row read.
// - addresses and write data are latched; read data is gated by enables.
// - transfer select picks the cycle type, then acts as read output enable.
// - transfer select high at row strobe fall keeps registers isolated.
// - transfer select low at row strobe fall connects registers to the row.
// - each row splits into four 64-column sections matching register segments.
// - write select low moves registers to array, high moves array to registers.
// - shift registers shift on each rising serial clock edge except one that takes a pending parallel load.
// - row address latched at row strobe fall, column at column strobe fall.
`timescale 1ns/1ps
module video_dram_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic row_strobe_n,
    input wire logic [vdram_pkg::SLICES-1:0] column_strobe_n,
    input wire logic write_select_n,
    input wire logic transfer_select_output_enable_n,
    input wire logic [vdram_pkg::ROW_BITS-1:0] multiplexed_address,
    input wire logic [vdram_pkg::SLICES-1:0] data_in,
    output logic [vdram_pkg::SLICES-1:0] data_out,
    output logic [vdram_pkg::SLICES-1:0] data_oe,
    input wire logic [vdram_pkg::SLICES-1:0] serial_input,
    output logic [vdram_pkg::SLICES-1:0] serial_output,
    output logic serial_output_oe,
    input wire logic serial_output_enable_n
);
    localparam logic [vdram_pkg::SLICES-1:0] SLICE_ZERO = vdram_pkg::SLICE_NONE;

    transfer_if xfer ();

    // pin levels after synchronisation
    logic [vdram_pkg::PIN_COUNT-1:0] pins_raw;
    logic [vdram_pkg::PIN_COUNT-1:0] pins;
    logic ras_s;
    logic [vdram_pkg::SLICES-1:0] cas_s;
    logic w_s;
    logic tr_s;
    logic [vdram_pkg::ROW_BITS-1:0] addr_s;
    logic [vdram_pkg::SLICES-1:0] dq_s;
    logic soe_s;

    // edge history
    logic ras_q;
    logic [vdram_pkg::SLICES-1:0] cas_q;
    logic w_q;
    logic ras_fall;
    logic ras_rise;
    logic [vdram_pkg::SLICES-1:0] cas_fall;
    logic [vdram_pkg::SLICES-1:0] cas_rise;
    logic w_fall;

    // cycle state
    vdram_pkg::cycle_e cyc;
    vdram_pkg::cycle_e next_cyc;
    logic [vdram_pkg::ROW_BITS-1:0] row_q;
    logic [vdram_pkg::COL_BITS-1:0] col_q;
    logic [vdram_pkg::SEG_CODE_W-1:0] seg_code;
    logic [vdram_pkg::SLICES-1:0] early_write;
    logic [vdram_pkg::SLICES-1:0] read_valid;
    logic [vdram_pkg::SLICES-1:0][vdram_pkg::COLS-1:0] load_row;
    logic load_toggle;

    // decoded actions
    logic in_random;
    logic start_to_array;
    logic end_to_reg;
    logic [vdram_pkg::SLICES-1:0] wr_bit;
    logic [vdram_pkg::SLICES-1:0] rd_bit;
    logic [vdram_pkg::COL_BITS-1:0] col_now;

    // storage: one 256 x 256 bit plane per slice
    logic [vdram_pkg::COLS-1:0] mem [vdram_pkg::SLICES][vdram_pkg::ROWS];

    assign pins_raw = {row_strobe_n, column_strobe_n, write_select_n,
                       transfer_select_output_enable_n, multiplexed_address,
                       data_in, serial_output_enable_n};

    // strobes idle high so no false edge appears after reset
    pin_sync #(
        .WIDTH(vdram_pkg::PIN_COUNT),
        .RESET_VALUE(20'hF_F801)
    ) u_pins (
        .clk(clk),
        .rst_n(rst_n),
        .pin(pins_raw),
        .level(pins)
    );

    assign {ras_s, cas_s, w_s, tr_s, addr_s, dq_s, soe_s} = pins;

    serial_shifter u_shifter (
        .serial_clock(serial_clock),
        .rst_n(rst_n),
        .xfer(xfer.shifter),
        .serial_input(serial_input),
        .serial_output(serial_output)
    );

    assign serial_output_oe = ~soe_s;

    // edge decode on synchronised levels
    assign ras_fall = ras_q & ~ras_s;
    assign ras_rise = ~ras_q & ras_s;
    assign cas_fall = cas_q & ~cas_s;
    assign cas_rise = ~cas_q & cas_s;
    assign w_fall = w_q & ~w_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ras_q <= 1'b1;
            cas_q <= 4'hF;
            w_q <= 1'b1;
        end else begin
            ras_q <= ras_s;
            cas_q <= cas_s;
            w_q <= w_s;
        end
    end

    // transfer select is looked at only on the row strobe fall
    always_comb begin
        next_cyc = cyc;
        unique case (cyc)
            vdram_pkg::CYC_IDLE: begin
                if (ras_fall) begin
                    if (tr_s) begin
                        next_cyc = vdram_pkg::CYC_RANDOM;
                    end else if (w_s) begin
                        next_cyc = vdram_pkg::CYC_TO_REG;
                    end else begin
                        next_cyc = vdram_pkg::CYC_TO_ARRAY;
                    end
                end
            end
            vdram_pkg::CYC_RANDOM, vdram_pkg::CYC_TO_ARRAY, vdram_pkg::CYC_TO_REG: begin
                if (ras_rise) begin
                    next_cyc = vdram_pkg::CYC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc <= vdram_pkg::CYC_IDLE;
        end else begin
            cyc <= next_cyc;
        end
    end

    assign in_random = (cyc == vdram_pkg::CYC_RANDOM);
    assign start_to_array = (cyc == vdram_pkg::CYC_IDLE) && ras_fall && !tr_s && !w_s;
    assign end_to_reg = (cyc == vdram_pkg::CYC_TO_REG) && ras_rise;

    // row on row strobe fall, column on any column strobe fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            row_q <= vdram_pkg::ROW_RESET;
        end else if (ras_fall) begin
            row_q <= addr_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= vdram_pkg::COL_RESET;
        end else if (|cas_fall) begin
            col_q <= addr_s;
        end
    end

    // segment code keeps its value unless a column strobe falls in a
    // register load cycle, so repeated transfers need no column strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_code <= vdram_pkg::SEG_CODE_RESET;
        end else if ((cyc == vdram_pkg::CYC_TO_REG) && (|cas_fall)) begin
            seg_code <= addr_s[vdram_pkg::SEG_CODE_MSB:vdram_pkg::SEG_CODE_LSB];
        end
    end

    // the column is taken live on the strobe edge, latched value afterwards
    assign col_now = (|cas_fall) ? addr_s : col_q;

    // early write: write select low at column fall; late write: write
    // select falls while the column strobe is low (read-modify-write)
    assign wr_bit = {vdram_pkg::SLICES{in_random}} &
                    ((cas_fall & {vdram_pkg::SLICES{~w_s}}) |
                     ({vdram_pkg::SLICES{w_fall}} & ~cas_s & ~cas_fall));
    assign rd_bit = {vdram_pkg::SLICES{in_random & w_s}} & cas_fall;

    // register contents are read only at the row strobe fall, so a still
    // serial clock is what keeps this wide word stable across domains
    always_ff @(posedge clk) begin
        for (int s = 0; s < vdram_pkg::SLICES; s++) begin
            if (start_to_array) begin
                mem[s][addr_s] <= xfer.shift_state[s];
            end else if (wr_bit[s]) begin
                mem[s][row_q][col_now] <= dq_s[s];
            end
        end
    end

    // read data is captured once per column strobe and only shown
    // through the enables below, so the pins stay quiet otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= SLICE_ZERO;
        end else begin
            for (int s = 0; s < vdram_pkg::SLICES; s++) begin
                if (rd_bit[s]) begin
                    data_out[s] <= mem[s][row_q][addr_s];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_valid <= SLICE_ZERO;
        end else begin
            read_valid <= (read_valid & ~cas_rise & ~wr_bit) | rd_bit;
        end
    end

    // an early write keeps the outputs off for the rest of the row cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            early_write <= SLICE_ZERO;
        end else if (ras_fall) begin
            early_write <= SLICE_ZERO;
        end else begin
            early_write <= early_write | (cas_fall & {vdram_pkg::SLICES{in_random & ~w_s}});
        end
    end

    assign data_oe = read_valid & ~early_write & ~cas_s &
                     {vdram_pkg::SLICES{in_random & ~tr_s}};

    // whole-row snapshot for the shifter; the read itself restores the row
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_row <= '0;
            load_toggle <= 1'b0;
        end else if (end_to_reg) begin
            for (int s = 0; s < vdram_pkg::SLICES; s++) begin
                load_row[s] <= mem[s][row_q];
            end
            load_toggle <= ~load_toggle;
        end
    end

    assign xfer.load_row = load_row;
    assign xfer.start_code = seg_code;
    assign xfer.load_toggle = load_toggle;
endmodule // video_dram_top
